// File: hw/segment_lcd_drive_control.v
// Segment LCD drive control: APB registers, display timing and waveform levels
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "lcd_drive_defs.vh"

// Summary of operation
// - Display tick is sub-clock divided by eight
// - Software bit picks internal or crystal sub-clock
// - Enable works when awake; sleep forces off
// - Control A bit 7 picks waveform A/B
// - Resistance field decodes fixed or quick-charge ladder
// - Quick charge uses 60k after common change
// - Quick charge lasts field plus one ticks
// - Top ratio field passed to analog ladder
// - Duty field picks four, six, eight, five commons
// - Bias field picks third, quarter, half bias
// - Unimplemented control bits read as zero
// - Internal reset is not-enable OR sleep
// - Sleep with display on drives lines low
// - Full reset floats lines; watchdog excluded
// - Frame has one slot per active common
// - Every pixel sees zero average voltage
// - Style B alternates slower than style A
// - Level count follows bias ratio
// - Unused commons released for other functions
// - Segments follow display memory continuously
module segment_lcd_drive_control (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Sub-clock sources and power state
    input wire internal_slow_oscillator,
    input wire external_slow_crystal,
    input wire sleep_mode,
    // Backplane lines, 3-bit level code each
    output reg [23:0] backplane_line,
    output reg [7:0] backplane_line_oe,
    // Segment lines, 3-bit level code each
    output reg [95:0] segment_line,
    output reg segment_line_oe,
    // Analog ladder control
    output reg ladder_enable,
    output reg [1:0] ladder_resistance_select,
    output reg [3:0] top_level_ratio,
    output reg [1:0] level_ratio_select
);

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Number of active commons for a duty code
    // Code 11 maps to five commons, not to the next larger count
    function [3:0] com_count;
        input [1:0] duty;
        begin
            case (duty)
                `DUTY_4: com_count = `COMS_4;
                `DUTY_6: com_count = `COMS_6;
                `DUTY_8: com_count = `COMS_8;
                default: com_count = `COMS_5;
            endcase
        end
    endfunction

    // Level steps for a bias code; unimplemented code falls back to third
    function [2:0] bias_steps;
        input [1:0] bias;
        begin
            case (bias)
                `BIAS_QUARTER: bias_steps = `STEPS_4;
                `BIAS_HALF: bias_steps = `STEPS_2;
                default: bias_steps = `STEPS_3;
            endcase
        end
    endfunction

    // Level code: role 0 selected common, 1 idle common, 2 segment on, 3 segment off
    // Selected common plus segment on always sums to k: a lit pixel sees full swing
    // Code c means c/k of the top level; phase p flips polarity
    function [2:0] level;
        input [2:0] k;
        input [1:0] role;
        input p;
        begin
            case (role)
                2'h0: level = p ? `LVL_GND : k;
                2'h1: level = (k == `STEPS_2) ? 3'h1 : (p ? k - 3'h1 : 3'h1);
                2'h2: level = p ? k : `LVL_GND;
                default: level = (k == `STEPS_2) ? (p ? `LVL_GND : k) :
                                 (p ? k - 3'h2 : 3'h2);
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers and state

    reg [7:0] ctrl_a_ff; // Waveform style, resistance, enable
    reg [7:0] ctrl_b_ff; // Quick charge time, top ratio
    reg [7:0] ctrl_c_ff; // Duty and bias
    reg [7:0] clk_sel_ff; // Bit 0: crystal when set
    reg [31:0] mem_ff [0:7]; // Display memory, one word per common
    reg src_prev_ff; // Last sampled sub-clock level
    reg [2:0] div_ff; // Divide-by-eight counter
    reg tick_ff; // Display tick within slot
    reg [2:0] slot_ff; // Current common slot
    reg frame_par_ff; // Frame parity for style B
    reg qc_active_ff; // Low-resistance interval running
    reg [2:0] qc_cnt_ff; // Sub ticks left in interval
    reg awake_ff; // Set once after full reset release

    // Field views
    // No field spans two registers, so each view is a plain slice
    wire style_b = ctrl_a_ff[`A_TYPE];
    wire [2:0] rsel = ctrl_a_ff[`A_RSEL_HI:`A_RSEL_LO];
    wire [2:0] qct = ctrl_b_ff[`B_QCT_HI:`B_QCT_LO];
    wire [1:0] duty = ctrl_c_ff[`C_DUTY_HI:`C_DUTY_LO];
    wire [1:0] bias = ctrl_c_ff[`C_BIAS_HI:`C_BIAS_LO];
    wire [3:0] ncom = com_count(duty);
    wire [2:0] steps = bias_steps(bias);

    // Internal display reset; sleep overrides the enable
    wire disp_rst = ~ctrl_a_ff[`A_ON] | sleep_mode;

    // Sub-clock choice and edge; inputs are synchronous to pclk
    wire src = clk_sel_ff[0] ? external_slow_crystal : internal_slow_oscillator;
    // A source switch may add one early sub tick; it nudges the divider and the quick charge count
    wire sub_tick = src & ~src_prev_ff;
    wire disp_tick = sub_tick & (div_ff == `SUB_DIV_LAST);
    // Two display ticks per slot let style A swap polarity inside each slot
    wire slot_end = disp_tick & (tick_ff == `SLOT_TICK_LAST);
    wire frame_end = slot_end & ({1'b0, slot_ff} == ncom - 4'h1);

    // Style A flips every tick; style B flips only per frame
    wire phase = style_b ? frame_par_ff : tick_ff;

    // Quick charge modes
    wire qc_mode = (rsel[2] | (rsel[1:0] == 2'h3));
    wire [1:0] high_res = rsel[2] ? `LAD_225K : `LAD_1170K;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    // Every access is answered in its first access cycle, with no wait states
    wire setup = psel & ~penable;
    wire wr_go = psel & penable & pready & pwrite;
    wire in_mem = (paddr >= `OFF_MEM_BASE) & (paddr <= `OFF_MEM_LAST);
    wire [2:0] mem_idx = paddr[4:2];
    wire mapped = (paddr == `OFF_CTRL_A) | (paddr == `OFF_CTRL_B) |
                  (paddr == `OFF_CTRL_C) | (paddr == `OFF_CLK_SEL) |
                  (paddr == `OFF_STATUS) | (in_mem & (paddr[1:0] == 2'h0));
    wire ctl_wr = wr_go & pstrb[0];

    // Read mux; unimplemented bits are masked
    reg [31:0] rd_val;
    always @* begin
        rd_val = `RST_WORD;
        case (paddr)
            `OFF_CTRL_A: rd_val = {24'h000000, ctrl_a_ff & `MASK_A};
            `OFF_CTRL_B: rd_val = {24'h000000, ctrl_b_ff & `MASK_B};
            `OFF_CTRL_C: rd_val = {24'h000000, ctrl_c_ff & `MASK_C};
            `OFF_CLK_SEL: rd_val = {24'h000000, clk_sel_ff & `MASK_CLK};
            // Status is a live view of the sequencer; it has no write path
            `OFF_STATUS: rd_val = {26'h0, qc_active_ff, phase,
                                   ~disp_rst, slot_ff[2:0]};
            default: begin
                if (in_mem) begin
                    rd_val = mem_ff[mem_idx];
                end
            end
        endcase
    end

    // Answer one cycle after setup: pready high in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                // Refused reads return zero, never a stray memory word
                prdata <= (pwrite | ~mapped) ? `RST_WORD : rd_val;
                pslverr <= ~mapped;
            end else begin
                prdata <= `RST_WORD;
                pslverr <= 1'b0;
            end
        end
    end

    // Control registers, byte lane 0 only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_ff <= `RST_BYTE;
            ctrl_b_ff <= `RST_BYTE;
            ctrl_c_ff <= `RST_BYTE;
            clk_sel_ff <= `RST_BYTE;
        end else if (ctl_wr) begin
            if (paddr == `OFF_CTRL_A) begin
                ctrl_a_ff <= pwdata[7:0] & `MASK_A;
            end
            if (paddr == `OFF_CTRL_B) begin
                ctrl_b_ff <= pwdata[7:0] & `MASK_B;
            end
            if (paddr == `OFF_CTRL_C) begin
                ctrl_c_ff <= pwdata[7:0] & `MASK_C;
            end
            if (paddr == `OFF_CLK_SEL) begin
                clk_sel_ff <= pwdata[7:0] & `MASK_CLK;
            end
        end
    end

    // Display memory with byte strobes; kept across display reset
    integer b;
    integer w;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (w = 0; w < 8; w = w + 1) begin
                mem_ff[w] <= `RST_WORD;
            end
        end else if (wr_go & in_mem & (paddr[1:0] == 2'h0)) begin
            // Unaligned addresses are refused, so they must not land in memory
            for (b = 0; b < 4; b = b + 1) begin
                if (pstrb[b]) begin
                    mem_ff[mem_idx][b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Display timing

    // Divider and slot sequencer, held in reset while the display is off
    // Counters restart at zero, so each enable begins its frame at common 0
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_ff <= 1'b0;
            div_ff <= 3'h0;
            tick_ff <= 1'b0;
            slot_ff <= 3'h0;
            frame_par_ff <= 1'b0;
        end else begin
            src_prev_ff <= src;
            if (disp_rst) begin
                div_ff <= 3'h0;
                tick_ff <= 1'b0;
                slot_ff <= 3'h0;
                frame_par_ff <= 1'b0;
            end else begin
                if (sub_tick) begin
                    div_ff <= div_ff + 3'h1;
                end
                if (disp_tick) begin
                    tick_ff <= ~tick_ff;
                end
                if (frame_end) begin
                    // Wrap to the first common
                    slot_ff <= 3'h0;
                    frame_par_ff <= ~frame_par_ff;
                end else if (slot_end) begin
                    slot_ff <= slot_ff + 3'h1;
                end
            end
        end
    end

    // Quick charge interval, restarted at each common change
    // A new time field written mid-interval applies from the next common change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qc_active_ff <= 1'b0;
            qc_cnt_ff <= 3'h0;
        end else if (disp_rst) begin
            qc_active_ff <= 1'b0;
            qc_cnt_ff <= 3'h0;
        end else if (slot_end) begin
            // Count covers field plus one sub ticks
            qc_active_ff <= 1'b1;
            qc_cnt_ff <= qct;
        end else if (sub_tick & qc_active_ff) begin
            if (qc_cnt_ff == 3'h0) begin
                qc_active_ff <= 1'b0;
            end else begin
                qc_cnt_ff <= qc_cnt_ff - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output levels

    // All level logic is combinational here and registered once below
    reg [23:0] nxt_backplane_line;
    reg [7:0] nxt_backplane_line_oe;
    reg [95:0] nxt_segment_line;
    reg [1:0] nxt_ladder_resistance_select;
    reg [31:0] cur_word;
    integer i;
    always @* begin
        nxt_backplane_line = 24'h000000;
        nxt_backplane_line_oe = 8'h00;
        nxt_segment_line = {96{1'b0}};
        cur_word = mem_ff[slot_ff];
        // Backplanes: selected one at full swing, others at idle level
        for (i = 0; i < 8; i = i + 1) begin
            // Commons beyond the duty are released
            nxt_backplane_line_oe[i] = (i < ncom);
            if (!disp_rst && (i < ncom)) begin
                nxt_backplane_line[i*3 +: 3] = (i == slot_ff) ?
                    level(steps, 2'h0, phase) : level(steps, 2'h1, phase);
            end
        end
        // Segments read the memory word of the current slot
        for (i = 0; i < 32; i = i + 1) begin
            if (!disp_rst) begin
                nxt_segment_line[i*3 +: 3] = cur_word[i] ?
                    level(steps, 2'h2, phase) : level(steps, 2'h3, phase);
            end
        end
        // Ladder choice: 60k during quick charge, else the fixed pick
        if (qc_mode) begin
            nxt_ladder_resistance_select = qc_active_ff ? `LAD_60K : high_res;
        end else begin
            nxt_ladder_resistance_select = rsel[1:0];
        end
    end

    // Registered outputs; float until the second edge after full reset
    // Enables stay high in display reset: lines are held low, not floated
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_ff <= 1'b0;
            backplane_line <= 24'h000000;
            backplane_line_oe <= 8'h00;
            segment_line <= {96{1'b0}};
            segment_line_oe <= 1'b0;
            ladder_enable <= 1'b0;
            ladder_resistance_select <= `LAD_1170K;
            top_level_ratio <= 4'h0;
            level_ratio_select <= `BIAS_THIRD;
        end else begin
            awake_ff <= 1'b1;
            // Low while in display reset, driven once awake
            backplane_line <= nxt_backplane_line;
            backplane_line_oe <= awake_ff ? nxt_backplane_line_oe : 8'h00;
            segment_line <= nxt_segment_line;
            segment_line_oe <= awake_ff;
            // DC path of the ladder cut while the display is off
            ladder_enable <= ~disp_rst;
            ladder_resistance_select <= nxt_ladder_resistance_select;
            top_level_ratio <= ctrl_b_ff[`B_TOP_HI:`B_TOP_LO];
            level_ratio_select <= bias;
        end
    end

endmodule // segment_lcd_drive_control

// File: hw/lcd_drive_defs.vh
// Register map, field positions and timing constants for the LCD drive block
`ifndef LCD_DRIVE_DEFS_VH
`define LCD_DRIVE_DEFS_VH

// Register byte offsets
`define OFF_CTRL_A 12'h000
`define OFF_CTRL_B 12'h004
`define OFF_CTRL_C 12'h008
`define OFF_CLK_SEL 12'h00C
`define OFF_STATUS 12'h010
`define OFF_MEM_BASE 12'h040
`define OFF_MEM_LAST 12'h05C

// Control A fields
`define A_TYPE 7
`define A_RSEL_HI 3
`define A_RSEL_LO 1
`define A_ON 0

// Control B fields
`define B_QCT_HI 7
`define B_QCT_LO 5
`define B_TOP_HI 3
`define B_TOP_LO 0

// Control C fields
`define C_DUTY_HI 3
`define C_DUTY_LO 2
`define C_BIAS_HI 1
`define C_BIAS_LO 0

// Writable masks, unimplemented bits read zero
`define MASK_A 8'h8F
`define MASK_B 8'hEF
`define MASK_C 8'h0F
`define MASK_CLK 8'h01

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000

// Sub-clock divider to display tick, divide by 8
`define SUB_DIV_LAST 3'h7

// Display ticks per common slot, minus one
`define SLOT_TICK_LAST 1'h1

// Ladder resistance codes
`define LAD_1170K 2'h0
`define LAD_225K 2'h1
`define LAD_60K 2'h2

// Bias ratio codes
`define BIAS_THIRD 2'h0
`define BIAS_QUARTER 2'h1
`define BIAS_HALF 2'h2

// Level steps per bias ratio
`define STEPS_2 3'h2
`define STEPS_3 3'h3
`define STEPS_4 3'h4

// Duty codes and common counts
`define DUTY_4 2'h0
`define DUTY_6 2'h1
`define DUTY_8 2'h2
`define COMS_4 4'h4
`define COMS_5 4'h5
`define COMS_6 4'h6
`define COMS_8 4'h8

// Level code for ground
`define LVL_GND 3'h0

`endif

// File: tb/lcd_drive_monitor.sv
// Port checker for the segment LCD drive block
`timescale 1ns/1ps
`include "lcd_drive_defs.vh"
module lcd_drive_monitor (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    // Display side
    input wire logic [23:0] backplane_line,
    input wire logic [7:0] backplane_line_oe,
    input wire logic [95:0] segment_line,
    input wire logic segment_line_oe,
    input wire logic ladder_enable,
    input wire logic [1:0] ladder_resistance_select,
    input wire logic [3:0] top_level_ratio
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // Bus phases
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> answer_s) else $error("late ready");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("rdata not 0");
    ctrl_read_mask_a: assert property (pready && !pwrite |->
        !(paddr == `OFF_CTRL_A && prdata[6:4] != 3'h0) && !(paddr == `OFF_CTRL_B && prdata[4])
        && !(paddr == `OFF_CTRL_C && prdata[7:4] != 4'h0)) else $error("reserved bit set");
    ////////////////////////////////////////////////////////////////////////////
    // Display outputs
    commons_mask_a: assert property (
        backplane_line_oe inside {8'h00, 8'h0F, 8'h1F, 8'h3F, 8'hFF}) else $error("bad oe");
    sleep_low_a: assert property (sleep_mode [*3] |-> !ladder_enable &&
        backplane_line == 24'h0 && segment_line == 96'h0) else $error("sleep not low");
    reset_float_a: assert property (disable iff (1'b0) !presetn |->
        backplane_line_oe == 8'h00 && !segment_line_oe) else $error("reset not floating");
    ladder_code_a: assert property (ladder_resistance_select != 2'h3) else $error("bad ladder");
    top_ratio_write_a: assert property ($changed(top_level_ratio) |->
        $past(psel && penable && pwrite && paddr == `OFF_CTRL_B, 2)) else $error("ratio moved");
endmodule // lcd_drive_monitor
bind segment_lcd_drive_control lcd_drive_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .backplane_line(backplane_line), .backplane_line_oe(backplane_line_oe),
    .segment_line(segment_line), .segment_line_oe(segment_line_oe),
    .ladder_enable(ladder_enable), .ladder_resistance_select(ladder_resistance_select),
    .top_level_ratio(top_level_ratio));

// File: tb/lcd_panel_model.sv
// Passive panel model: one pixel's net voltage and backplane activity
`timescale 1ns/1ps
module lcd_panel_model (
    // Clock and clear
    input wire logic pclk,
    input wire logic clear,
    // Pixel at backplane 0 and segment 0
    input wire logic [2:0] backplane_code,
    input wire logic [2:0] segment_code,
    output int dc_sum,
    output int flips
);
    logic [2:0] last_code = 3'h0; // Previous backplane level
    // A net bias left on the pixel damages the liquid, so it is summed here
    always @(posedge pclk) begin
        last_code <= backplane_code;
        if (clear) begin
            dc_sum <= 0;
            flips <= 0;
        end else begin
            dc_sum <= dc_sum + int'(backplane_code) - int'(segment_code);
            flips <= flips + int'(backplane_code != last_code);
        end
    end
endmodule // lcd_panel_model

// File: tb/testbench.sv
// Self-checking bench for the segment LCD drive block
`timescale 1ns/1ps
`include "lcd_drive_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
    logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, seg_oe, lad_en, clear = 1, int_run = 1;
    logic internal_slow_oscillator = 0, external_slow_crystal = 0;
    logic [1:0] div = 2'h0, lad, bias;
    logic [23:0] bl;
    logic [7:0] bl_oe;
    logic [95:0] sl;
    logic [3:0] top;
    int n_tests = 0, n_mismatch = 0, dc_sum, flips;
    segment_lcd_drive_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_slow_oscillator(internal_slow_oscillator),
        .external_slow_crystal(external_slow_crystal), .sleep_mode(sleep_mode),
        .backplane_line(bl), .backplane_line_oe(bl_oe), .segment_line(sl),
        .segment_line_oe(seg_oe), .ladder_enable(lad_en), .ladder_resistance_select(lad),
        .top_level_ratio(top), .level_ratio_select(bias));
    lcd_panel_model u_panel (.pclk(pclk), .clear(clear), .backplane_code(bl[2:0]),
        .segment_code(sl[2:0]), .dc_sum(dc_sum), .flips(flips));
    always #2 pclk = ~pclk;
    // Sub-clocks of four bus clocks keep a frame short
    always @(posedge pclk) begin
        div <= div + 2'h1;
        if (int_run) internal_slow_oscillator <= div[1];
        external_slow_crystal <= ~div[1];
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        end_of_test();
    endtask
    // One bus transfer; held until ready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 9; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 9) timeout();
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Backplane now in its select slot: ground or top level
    function automatic int sel_com();
        for (int i = 0; i < 8; i++) if (bl_oe[i] && bl[3*i+:3] inside {3'h0, 3'h3}) return i;
        return -1;
    endfunction
    task automatic wait_lad(input logic [1:0] v);
        int i;
        for (i = 0; i < 600 && lad !== v; i++) @(posedge pclk);
        if (i == 600) timeout();
    endtask
    task automatic wait_sel(input int s, output int n);
        for (n = 0; n < 400 && sel_com() == s; n++) @(posedge pclk);
        if (n == 400) timeout();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] m[3] = '{`MASK_A, `MASK_B, `MASK_C};
        for (int i = 0; i < 3; i++) begin
            apb(0, `OFF_CTRL_A + 12'(4 * i), 32'h0);
            `CHK(rd, `RST_WORD)
            apb(1, `OFF_CTRL_A + 12'(4 * i), 32'hFFFFFFFF);
            apb(0, `OFF_CTRL_A + 12'(4 * i), 32'h0);
            `CHK(rd, {24'h0, m[i]})
        end
        `CHK(top, 4'hF)
        apb(1, 12'h3F0, 32'h1);
        apb(0, 12'h3F0, 32'h0);
        `CHK({er, rd}, 33'h100000000)
    endtask
    task automatic t_duty();
        logic [7:0] m[4] = '{8'h0F, 8'h3F, 8'hFF, 8'h1F};
        for (int d = 0; d < 4; d++) begin
            apb(1, `OFF_CTRL_C, 32'(d * 4 + (d % 3)));
            repeat (3) @(posedge pclk);
            `CHK(bl_oe, m[d])
            `CHK(bias, 2'(d % 3))
        end
    endtask
    task automatic t_ladder();
        logic [7:0] a[4] = '{8'h09, 8'h09, 8'h09, 8'h07};
        int q[4] = '{0, 3, 7, 0};
        int n;
        for (int r = 0; r < 3; r++) begin
            apb(1, `OFF_CTRL_A, 32'(r * 2 + 1));
            repeat (3) @(posedge pclk);
            `CHK({lad_en, lad}, 3'(4 + r))
        end
        for (int i = 0; i < 4; i++) begin
            apb(1, `OFF_CTRL_A, {24'h0, a[i]});
            apb(1, `OFF_CTRL_B, 32'(q[i] * 32));
            wait_lad(a[i] == 8'h09 ? 2'h1 : 2'h0);
            wait_lad(2'h2);
            for (n = 0; n < 99 && lad === 2'h2; n++) @(posedge pclk);
            `CHK(n, (q[i] + 1) * 4)
        end
        apb(1, `OFF_CTRL_A, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK(lad_en, 1'b0)
    endtask
    task automatic t_slots();
        int s, n;
        apb(1, `OFF_MEM_BASE, 32'h1);
        apb(1, `OFF_CTRL_C, 32'h4);
        apb(1, `OFF_CTRL_A, 32'h1);
        for (int k = 0; k < 8; k++) begin
            s = sel_com();
            wait_sel(s, n);
            if (k > 0) `CHK(n, 64)
            if (k > 0) `CHK(sel_com(), (s + 1) % 6)
            if (sel_com() == 0) `CHK(sl[2:0], 3'h3 - bl[2:0])
        end
    endtask
    task automatic t_clksel();
        int n;
        int_run <= 0;
        apb(1, `OFF_CLK_SEL, 32'h1);
        wait_sel(sel_com(), n);
        apb(1, `OFF_CLK_SEL, 32'h0);
        // The switch itself may give one sub tick; let it settle first
        repeat (2) @(posedge pclk);
        n = sel_com();
        repeat (200) @(posedge pclk);
        `CHK(sel_com(), n)
        int_run <= 1;
    endtask
    task automatic t_sleep();
        sleep_mode <= 1;
        repeat (4) @(posedge pclk);
        `CHK({lad_en, bl, bl_oe}, 33'h3F)
        sleep_mode <= 0;
        repeat (4) @(posedge pclk);
        `CHK(lad_en, 1'b1)
    endtask
    task automatic t_style();
        int fa;
        apb(1, `OFF_CTRL_C, 32'h0);
        clear <= 0;
        repeat (1024) @(posedge pclk);
        fa = flips;
        `CHK(dc_sum <= 192 && dc_sum >= -192, 1'b1)
        apb(1, `OFF_CTRL_A, 32'h81);
        clear <= 1;
        @(posedge pclk);
        clear <= 0;
        repeat (1024) @(posedge pclk);
        `CHK(flips < fa, 1'b1)
    endtask
    // All segments lit: segment top level and idle common level follow the bias
    task automatic t_bias();
        logic [2:0] k[3] = '{3'h3, 3'h4, 3'h2};
        int idle[3] = '{2, 3, 1};
        int i, s;
        for (i = 0; i < 4; i++) apb(1, `OFF_MEM_BASE + 12'(4 * i), 32'hFFFFFFFF);
        for (int b = 0; b < 3; b++) begin
            apb(1, `OFF_CTRL_C, 32'(b));
            @(posedge pclk);
            for (i = 0; i < 600 && sl[2:0] == 3'h0; i++) @(posedge pclk);
            if (i == 600) timeout();
            s = int'(bl[2:0]) + int'(bl[5:3]) + int'(bl[8:6]) + int'(bl[11:9]);
            `CHK(sl[2:0], k[b])
            `CHK(s, 3 * idle[b])
        end
    endtask
    task automatic t_reset();
        presetn <= 0;
        @(posedge pclk);
        `CHK({bl_oe, seg_oe}, 9'h000)
        presetn <= 1;
        repeat (3) @(posedge pclk);
        `CHK({bl_oe, seg_oe}, 9'h01F)
        apb(0, `OFF_CTRL_A, 32'h0);
        `CHK(rd, `RST_WORD)
    endtask
    initial begin
        // A real falling edge at time zero resets the design before the first clock
        presetn <= 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_duty();
        t_ladder();
        t_slots();
        t_clksel();
        t_sleep();
        t_style();
        t_bias();
        t_reset();
        end_of_test();
    end
endmodule // testbench
